// ==== otf_pkg.sv ====
// Constants and types for the transceiver control and status block
// -----------------------------------------------------------------------------
// Behaviour
// - Transmit-off high disables optical output
// - Floating transmit-off keeps laser disabled
// - Cycling transmit-off resets transmit section
// - Catastrophic fault raises fault and disables laser
// - Fault output low normally, high on fault
// - Fault latched; cleared by toggle or power
// - Fault mirrored in byte 110 bit 2
// - Unsafe power disables transmitter, raises fault
// - Loss output low with usable input
// - Loss from transition detection with thresholds
// - Loss mirrored in byte 110 bit 1
// -----------------------------------------------------------------------------
package otf_pkg;

    // -------------------------------------------------------------------------
    // Diagnostic register map
    // -------------------------------------------------------------------------
    localparam logic [7:0] DIAG_STATUS_CONTROL_BYTE_OFS = 8'h6E;
    localparam int         DIAG_FAULT_BIT               = 2;
    localparam int         DIAG_LOST_BIT                = 1;
    localparam logic [7:0] DIAG_RESET_VAL               = 8'h00;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 20;
    localparam int DISABLE_SPACING_MS = 10;
    localparam int DISABLE_SPACING_CYC =
        (DISABLE_SPACING_MS * 1000000) / CLK_PERIOD_NS;
    localparam int LOST_WIN_US  = 10;
    localparam int LOST_WIN_CYC = (LOST_WIN_US * 1000) / CLK_PERIOD_NS;
    localparam int LOST_CNT_W   = 16;
    localparam logic [7:0] LOST_ASSERT_THR   = 8'h10;
    localparam logic [7:0] LOST_DEASSERT_THR = 8'h18;

    // -------------------------------------------------------------------------
    // Transmit state machine
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_OFF   = 3'b001,
        TX_ON    = 3'b010,
        TX_FAULT = 3'b100
    } otf_tx_state_t;

endpackage : otf_pkg

// ==== otf_sig_if.sv ====
// Interface carrying receive activity between detector and top
`timescale 1ns/1ps
interface otf_sig_if;
    logic       edge_seen;
    logic [7:0] amp_level;
    logic       lost;

    modport det
    (
        input  edge_seen,
        input  amp_level,
        output lost
    );
    modport top
    (
        output edge_seen,
        output amp_level,
        input  lost
    );
endinterface : otf_sig_if

// ==== otf_lost_det.sv ====
// Loss-of-signal detector from transition activity and ac level
`timescale 1ns/1ps
module otf_lost_det
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Receive activity
    otf_sig_if.det    sig
);

    logic [otf_pkg::LOST_CNT_W-1:0] win_cnt_ff;
    logic                           edges_ff;
    logic [7:0]                     peak_ff;
    logic                           lost_ff;
    logic                           win_end;

    assign win_end = (win_cnt_ff ==
        otf_pkg::LOST_CNT_W'(otf_pkg::LOST_WIN_CYC - 1));

    // -------------------------------------------------------------------------
    // Observation window
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst || win_end)
            win_cnt_ff <= '0;
        else
            win_cnt_ff <= win_cnt_ff + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst || win_end)
        begin
            edges_ff <= 1'b0;
            peak_ff  <= 8'h00;
        end
        else
        begin
            if (sig.edge_seen)
                edges_ff <= 1'b1;
            if (sig.amp_level > peak_ff)
                peak_ff <= sig.amp_level;
        end
    end

    // -------------------------------------------------------------------------
    // Decision with hysteresis
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            lost_ff <= 1'b1;
        else if (win_end)
        begin
            if (!edges_ff || peak_ff < otf_pkg::LOST_ASSERT_THR)
                lost_ff <= 1'b1;
            else if (peak_ff >= otf_pkg::LOST_DEASSERT_THR)
                lost_ff <= 1'b0;
        end
    end

    assign sig.lost = lost_ff;

endmodule : otf_lost_det

// ==== otf_ctrl.sv ====
// Transceiver transmit-off, laser fault and loss-of-signal control
`timescale 1ns/1ps
module otf_ctrl
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Host control pin
    input  wire logic       tx_off,
    input  wire logic       tx_off_floating,
    // Laser monitors
    input  wire logic       laser_cat_fault,
    input  wire logic       power_unsafe,
    // Receive activity
    input  wire logic       rx_edge_seen,
    input  wire logic [7:0] rx_amp_level,
    // Laser drive
    output logic            laser_enable,
    // Host status pins
    output logic            tx_fault_out,
    output logic            receive_signal_lost,
    // Diagnostic byte read port
    input  wire logic [7:0] diag_addr,
    output logic [7:0]      diag_rdata
);

    otf_pkg::otf_tx_state_t state_ff;
    otf_pkg::otf_tx_state_t nxt_state;
    logic                   off_req;
    logic                   off_prev_ff;
    logic                   off_rise;
    logic                   fault_ev;
    logic                   fault_ff;
    logic                   laser_enable_ff;
    logic                   tx_fault_ff;
    logic                   lost_out_ff;
    logic [7:0]             diag_ff;
    logic [7:0]             nxt_diag;

    otf_sig_if sig ();

    // -------------------------------------------------------------------------
    // Transmit-off input and toggle detection
    // -------------------------------------------------------------------------
    assign off_req  = tx_off | tx_off_floating;
    assign fault_ev = laser_cat_fault | power_unsafe;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            off_prev_ff <= 1'b1;
        else
            off_prev_ff <= off_req;
    end

    assign off_rise = off_req & ~off_prev_ff;

    // -------------------------------------------------------------------------
    // Fault latch: set wins over toggle clear
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            fault_ff <= 1'b0;
        else if (fault_ev)
            fault_ff <= 1'b1;
        else if (off_rise)
            fault_ff <= 1'b0;
    end

    // -------------------------------------------------------------------------
    // Transmit state machine
    // -------------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            otf_pkg::TX_OFF:
                if (fault_ev)
                    nxt_state = otf_pkg::TX_FAULT;
                else if (!off_req && !fault_ff)
                    nxt_state = otf_pkg::TX_ON;
            otf_pkg::TX_ON:
                if (fault_ev)
                    nxt_state = otf_pkg::TX_FAULT;
                else if (off_req)
                    nxt_state = otf_pkg::TX_OFF;
            otf_pkg::TX_FAULT:
                if (off_rise && !fault_ev)
                    nxt_state = otf_pkg::TX_OFF;
            default:
                nxt_state = otf_pkg::TX_OFF;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_ff <= otf_pkg::TX_OFF;
        else
            state_ff <= nxt_state;
    end

    // -------------------------------------------------------------------------
    // Registered pin outputs
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            laser_enable_ff <= 1'b0;
            tx_fault_ff     <= 1'b0;
        end
        else
        begin
            laser_enable_ff <= (nxt_state == otf_pkg::TX_ON);
            tx_fault_ff     <= fault_ff | fault_ev;
        end
    end

    // -------------------------------------------------------------------------
    // Receive loss detection
    // -------------------------------------------------------------------------
    assign sig.edge_seen = rx_edge_seen;
    assign sig.amp_level = rx_amp_level;

    otf_lost_det u_lost_det
    (
        .clk_sys (clk_sys),
        .srst    (srst),
        .sig     (sig.det)
    );

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            lost_out_ff <= 1'b1;
        else
            lost_out_ff <= sig.lost;
    end

    // -------------------------------------------------------------------------
    // Diagnostic byte read
    // -------------------------------------------------------------------------
    always_comb
    begin
        nxt_diag = 8'h00;
        if (diag_addr == otf_pkg::DIAG_STATUS_CONTROL_BYTE_OFS)
        begin
            nxt_diag[otf_pkg::DIAG_FAULT_BIT] = tx_fault_ff;
            nxt_diag[otf_pkg::DIAG_LOST_BIT]  = lost_out_ff;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            diag_ff <= otf_pkg::DIAG_RESET_VAL;
        else
            diag_ff <= nxt_diag;
    end

    assign laser_enable        = laser_enable_ff;
    assign tx_fault_out        = tx_fault_ff;
    assign receive_signal_lost = lost_out_ff;
    assign diag_rdata          = diag_ff;

endmodule : otf_ctrl

// ==== otf_host_model.sv ====
// Host board model driving the transmit-off pin
`timescale 1ns/1ps
module otf_host_model
#(
    parameter int GAP_CYC = 50
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Request and pin
    input wire logic cycle_req,
    output logic     tx_off,
    output logic     ready
);
    logic [15:0] gap_ff;
    // One-cycle pulse, idle low when unused
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            tx_off <= 1'b0;
        else
            tx_off <= cycle_req && ready;
    end
    // Spacing scaled down from the 10 ms figure
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            gap_ff <= 16'h0000;
        else if (tx_off)
            gap_ff <= 16'(GAP_CYC);
        else if (gap_ff != 16'h0000)
            gap_ff <= gap_ff - 16'h0001;
    end
    assign ready = (gap_ff == 16'h0000) && !tx_off;
endmodule : otf_host_model

// ==== otf_ctrl_properties.sv ====
// Port assertions for the transceiver control block
`timescale 1ns/1ps
module otf_ctrl_properties
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       srst,
    // Pins
    input wire logic       tx_off,
    input wire logic       tx_off_floating,
    input wire logic       laser_cat_fault,
    input wire logic       power_unsafe,
    input wire logic       rx_edge_seen,
    input wire logic [7:0] rx_amp_level,
    input wire logic       laser_enable,
    input wire logic       tx_fault_out,
    input wire logic       receive_signal_lost,
    input wire logic [7:0] diag_addr,
    input wire logic [7:0] diag_rdata
);
    logic [10:0] quiet_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Cycles since the last receive transition
    always_ff @(posedge clk_sys)
    begin
        if (srst || rx_edge_seen)
            quiet_ff <= 11'h000;
        else if (quiet_ff != 11'h7FF)
            quiet_ff <= quiet_ff + 11'h001;
    end
    sequence s_cause;
        laser_cat_fault || power_unsafe;
    endsequence
    sequence s_run_ok;
        (!tx_off && !tx_off_floating && !tx_fault_out
         && !laser_cat_fault && !power_unsafe)[*3];
    endsequence
    a_off_stops_laser: assert property (tx_off |=> !laser_enable)
        else $error("laser on while off");
    a_open_stops_laser: assert property
        (tx_off_floating |=> !laser_enable) else $error("laser on, pin open");
    a_fault_raises_pin: assert property
        (s_cause |=> tx_fault_out && !laser_enable) else $error("fault missed");
    a_run_enables_laser: assert property (s_run_ok |=> laser_enable)
        else $error("laser not enabled");
    a_fault_blocks_laser: assert property
        (tx_fault_out |-> !laser_enable) else $error("laser on in fault");
    a_clear_needs_toggle: assert property ($fell(tx_fault_out) |->
        $past(tx_off) || $past(tx_off_floating) || $past(tx_off, 2)
        || $past(tx_off_floating, 2)) else $error("fault cleared alone");
    a_diag_mirror_bits: assert property (!$past(srst) &&
        $past(diag_addr) == otf_pkg::DIAG_STATUS_CONTROL_BYTE_OFS |->
        diag_rdata == {5'h00, $past(tx_fault_out),
        $past(receive_signal_lost), 1'b0}) else $error("status byte wrong");
    a_other_reads_zero: assert property (!$past(srst) &&
        $past(diag_addr) != otf_pkg::DIAG_STATUS_CONTROL_BYTE_OFS |->
        diag_rdata == 8'h00) else $error("other byte not zero");
    a_silence_is_lost: assert property
        (quiet_ff > 11'h3F2 |-> receive_signal_lost) else $error("no loss");
endmodule : otf_ctrl_properties
bind otf_ctrl otf_ctrl_properties u_props
(
    .clk_sys, .srst, .tx_off, .tx_off_floating, .laser_cat_fault,
    .power_unsafe, .rx_edge_seen, .rx_amp_level, .laser_enable,
    .tx_fault_out, .receive_signal_lost, .diag_addr, .diag_rdata
);

// ==== otf_ctrl_tb.sv ====
// Self-checking bench for the transceiver control block
`timescale 1ns/1ps
module otf_ctrl_tb;
    typedef struct packed {logic off, flt, cat, uns, fault, laser;} otf_pin_t;
    typedef struct packed {logic edge_on; logic [7:0] amp; logic lost;}
        otf_rx_t;
    otf_pin_t pins[5] = '{6'h01, 6'h20, 6'h10, 6'h0A, 6'h06};
    otf_rx_t rxr[6] = '{10'h240, 10'h228, 10'h20B, 10'h229, 10'h240, 10'h041};
    logic clk_sys = 1'b0, srst = 1'b1, row_off = 1'b0, cycle_req = 1'b0;
    logic tx_off_floating = 1'b0, laser_cat_fault = 1'b0, power_unsafe = 1'b0;
    logic rx_edge_seen = 1'b0, host_off, ready, laser_enable, tx_fault_out;
    logic receive_signal_lost;
    logic [7:0] rx_amp_level = 8'h00, diag_addr = 8'h6E, diag_rdata;
    wire logic tx_off = row_off | host_off;
    int failures = 0, n_tests = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    otf_host_model #(.GAP_CYC(50)) host
        (.clk_sys, .srst, .cycle_req, .tx_off(host_off), .ready);
    otf_ctrl dut (.clk_sys, .srst, .tx_off, .tx_off_floating,
        .laser_cat_fault, .power_unsafe, .rx_edge_seen, .rx_amp_level,
        .laser_enable, .tx_fault_out, .receive_signal_lost, .diag_addr,
        .diag_rdata);
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: bit %b not %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: byte %h not %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic recover;
        cycle_req = 1'b1;
        step(1);
        cycle_req = 1'b0;
        for (int k = 0; k < 100 && ready !== 1'b1; k++)
            step(1);
        step(4);
    endtask : recover
    task automatic print_verdict;
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            print_verdict();
        end
    end
    initial
    begin
        step(20);
        chk_bit(receive_signal_lost, 1'b1);
        chk_byte(diag_rdata, 8'h00);
        chk_bit(laser_enable, 1'b0);
        srst = 1'b0;
        step(5);
        foreach (pins[i])
        begin
            {row_off, tx_off_floating, laser_cat_fault, power_unsafe} =
                pins[i][5:2];
            step(3);
            chk_bit(laser_enable, pins[i].laser);
            chk_bit(tx_fault_out, pins[i].fault);
            chk_byte(diag_rdata, {5'h00, pins[i].fault, 2'h2});
            {row_off, tx_off_floating, laser_cat_fault, power_unsafe} = 4'h0;
            // Keep the host's spacing between off assertions
            step(50);
            chk_bit(tx_fault_out, pins[i].fault);
            recover();
            chk_bit(tx_fault_out, 1'b0);
            chk_bit(laser_enable, 1'b1);
        end
        // Fault in the same cycle as the toggle, then a mid-run reset
        laser_cat_fault = 1'b1;
        cycle_req = 1'b1;
        step(1);
        cycle_req = 1'b0;
        step(1);
        laser_cat_fault = 1'b0;
        diag_addr = 8'h6F;
        step(3);
        chk_bit(tx_fault_out, 1'b1);
        chk_byte(diag_rdata, 8'h00);
        diag_addr = 8'h6E;
        srst = 1'b1;
        step(2);
        chk_bit(tx_fault_out, 1'b0);
        srst = 1'b0;
        step(60);
        foreach (rxr[i])
        begin
            {rx_edge_seen, rx_amp_level} = rxr[i][9:1];
            step(1100);
            chk_bit(receive_signal_lost, rxr[i].lost);
            chk_byte(diag_rdata, {6'h00, rxr[i].lost, 1'b0});
        end
        print_verdict();
    end
endmodule : otf_ctrl_tb
